/* rtl/rx_adaptive_equalizer_ctl.sv */
`timescale 1ns/1ps
module rx_adaptive_equalizer_ctl
  import eq_ctl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire eq_ctl_pkg::reg_req_t req,
  input wire eq_ctl_pkg::eq_in_t eq_in [4],
  output logic [7:0] rdata,
  output logic [5:0] eq_setting [4],
  output logic lock_out [4]
);
  import eq_ctl_pkg::*;

  function automatic logic [31:0] wait_cycles(input logic [2:0] code);
    wait_cycles = 32'((RELOCK_NS[code] + CLK_NS - 1) / CLK_NS);
  endfunction

  function automatic logic [3:0] ceiling_of(input logic [7:0] lim);
    ceiling_of = lim[POS_CEIL +: 4];
  endfunction

  function automatic logic [3:0] start_of(input logic [7:0] ctl, input logic [7:0] lim);
    start_of = ctl[POS_FLOOR_EN] ? lim[POS_FLOOR_VAL +: 4] : 4'h0;
  endfunction

  logic [7:0] ctl_q [4], ctl_d [4];
  logic [7:0] byp_q [4], byp_d [4];
  logic [7:0] lim_q [4], lim_d [4];
  logic lim_flag_q [4], lim_flag_d [4];
  logic stab_q [4], stab_d [4];
  logic [3:0] set_q [4], set_d [4];
  logic [31:0] cnt_q [4], cnt_d [4];
  logic seen_lock_q [4], seen_lock_d [4];
  logic done_q [4], done_d [4];
  logic [5:0] eqs_q [4], eqs_d [4];
  logic lock_q [4], lock_d [4];
  logic [7:0] rdata_d;

  // register bank and flags
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      logic sel;
      logic [3:0] start;
      sel = (req.port == 2'(p));
      start = start_of(ctl_q[p], lim_q[p]);
      ctl_d[p] = ctl_q[p];
      byp_d[p] = byp_q[p];
      lim_d[p] = lim_q[p];
      ctl_d[p][POS_RESTART] = 1'b0;
      lim_flag_d[p] = lim_flag_q[p];
      stab_d[p] = stab_q[p];
      // only the selected port is touched
      if (sel && req.wr) begin
        case (req.addr)
          OFS_CTL_TWO: ctl_d[p] = {req.wdata[7:2], 2'b00};
          OFS_BYPASS: byp_d[p] = req.wdata;
          OFS_LIMITS: lim_d[p] = req.wdata;
          default: ;
        endcase
      end
      // read clears the limit flag and re-arms settled, a new event wins
      if (sel && req.rd && req.addr == OFS_FILT0) begin
        lim_flag_d[p] = 1'b0;
        stab_d[p] = eq_in[p].settled;
      end
      if (eq_in[p].at_limit) lim_flag_d[p] = 1'b1;
      if (!eq_in[p].settled) stab_d[p] = 1'b0;

      set_d[p] = set_q[p];
      cnt_d[p] = cnt_q[p];
      seen_lock_d[p] = seen_lock_q[p];
      done_d[p] = done_q[p];
      if (eq_in[p].lock_raw) begin
        seen_lock_d[p] = 1'b1;
        cnt_d[p] = '0;
        done_d[p] = 1'b1;
        if (!seen_lock_q[p] && ctl_q[p][POS_FIRST_LOCK]) begin
          set_d[p] = 4'h0;
          done_d[p] = 1'b0;
        end
      end else begin
        done_d[p] = 1'b0;
        if (cnt_q[p] + 32'd1 >= wait_cycles(ctl_q[p][POS_RELOCK +: 3])) begin
          cnt_d[p] = '0;
          if (set_q[p] < ceiling_of(lim_q[p])) set_d[p] = set_q[p] + 4'h1;
          else set_d[p] = start;
        end else begin
          cnt_d[p] = cnt_q[p] + 32'd1;
        end
      end
      if (ctl_q[p][POS_RESTART]) begin
        set_d[p] = start;
        cnt_d[p] = '0;
        done_d[p] = 1'b0;
      end
      // a lowered ceiling pulls the setting down on the next cycle
      if (set_d[p] > ceiling_of(lim_q[p])) set_d[p] = ceiling_of(lim_q[p]);
      if (byp_q[p][POS_BYPASS]) begin
        eqs_d[p] = {byp_q[p][POS_MAN_HIGH +: 3], byp_q[p][POS_MAN_LOW +: 3]};
      end else begin
        eqs_d[p] = {2'b00, set_q[p]};
      end
      lock_d[p] = eq_in[p].lock_raw &&
                  (!byp_q[p][POS_LOCK_MODE] || done_q[p] || byp_q[p][POS_BYPASS]);
    end
  end

  // read mux
  always_comb begin
    logic [1:0] s;
    s = req.port;
    rdata_d = 8'h00;
    if (req.rd) begin
      case (req.addr)
        OFS_CTL_TWO: rdata_d = ctl_q[s];
        OFS_STATUS: rdata_d = {2'b00, eqs_q[s]};
        OFS_BYPASS: rdata_d = byp_q[s];
        OFS_LIMITS: rdata_d = lim_q[s];
        OFS_FILT0: rdata_d = {lim_flag_q[s], stab_q[s], eq_in[s].clk_delay};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
      for (int p = 0; p < NUM_PORTS; p++) begin
        ctl_q[p] <= RST_CTL_TWO;
        byp_q[p] <= RST_BYPASS;
        lim_q[p] <= RST_LIMITS;
        lim_flag_q[p] <= 1'b0;
        stab_q[p] <= 1'b0;
        set_q[p] <= 4'h0;
        cnt_q[p] <= '0;
        seen_lock_q[p] <= 1'b0;
        done_q[p] <= 1'b0;
        eqs_q[p] <= 6'h00;
        lock_q[p] <= 1'b0;
      end
    end else begin
      rdata <= rdata_d;
      for (int p = 0; p < NUM_PORTS; p++) begin
        ctl_q[p] <= ctl_d[p];
        byp_q[p] <= byp_d[p];
        lim_q[p] <= lim_d[p];
        lim_flag_q[p] <= lim_flag_d[p];
        stab_q[p] <= stab_d[p];
        set_q[p] <= set_d[p];
        cnt_q[p] <= cnt_d[p];
        seen_lock_q[p] <= seen_lock_d[p];
        done_q[p] <= done_d[p];
        eqs_q[p] <= eqs_d[p];
        lock_q[p] <= lock_d[p];
      end
    end
  end

  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      eq_setting[p] = eqs_q[p];
      lock_out[p] = lock_q[p];
    end
  end

  default clocking cb_main @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence seq_filt_read;
    req.rd && req.port == 2'd0 && req.addr == OFS_FILT0;
  endsequence

  sequence seq_ctl_write;
    req.wr && req.port == 2'd0 && req.addr == OFS_CTL_TWO;
  endsequence

  sequence seq_first_lock;
    eq_in[0].lock_raw && !seen_lock_q[0] && ctl_q[0][POS_FIRST_LOCK] && !ctl_q[0][POS_RESTART];
  endsequence

  sequence seq_still_hunting;
    !eq_in[0].lock_raw && !ctl_q[0][POS_RESTART] && set_q[0] <= ceiling_of(lim_q[0]);
  endsequence

  a_restart_pulse: assert property (
    ctl_q[0][POS_RESTART] |=> !ctl_q[0][POS_RESTART]
  ) else $error("restart stuck");

  // setting under ceiling; the cap applies one cycle after a write
  a_ceiling_held: assert property (
    set_q[0] <= $past(lim_q[0][7:4])
  ) else $error("setting above ceiling");

  a_bypass_value: assert property (
    byp_q[0][0] |=> eqs_q[0] == {$past(byp_q[0][7:5]), $past(byp_q[0][3:1])}
  ) else $error("bypass setting wrong");

  a_lock_raw: assert property (
    !eq_in[0].lock_raw |=> !lock_q[0]
  ) else $error("lock without detector");

  a_limit_sets: assert property (
    eq_in[0].at_limit |=> lim_flag_q[0]
  ) else $error("limit flag missed");

  a_settled_low: assert property (
    !eq_in[0].settled |=> !stab_q[0]
  ) else $error("settled not low");

  a_reserved_zero: assert property (
    ctl_q[0][1:0] == 2'b00
  ) else $error("reserved bits set");

  a_status_read: assert property (
    (req.rd && req.addr == OFS_STATUS) |=> rdata[7:6] == 2'b00
  ) else $error("status top");

  a_dwell_hold: assert property (
    seq_still_hunting ##0 (cnt_q[0] + 32'd1 < wait_cycles(ctl_q[0][POS_RELOCK +: 3])) |=> $stable(set_q[0])
  ) else $error("setting stepped early");

  a_restart_start: assert property (
    ctl_q[0][POS_RESTART] && start_of(ctl_q[0], lim_q[0]) <= ceiling_of(lim_q[0]) |=> set_q[0] == $past(start_of(ctl_q[0], lim_q[0]))
  ) else $error("restart start wrong");

  a_first_lock: assert property (
    seq_first_lock |=> set_q[0] == 4'h0
  ) else $error("first lock not zero");

  a_mode_off: assert property (
    eq_in[0].lock_raw && !byp_q[0][POS_LOCK_MODE] |=> lock_q[0]
  ) else $error("lock not reported");

  a_needs_done: assert property (
    eq_in[0].lock_raw && byp_q[0][POS_LOCK_MODE] && !byp_q[0][POS_BYPASS] && !done_q[0] |=> !lock_q[0]
  ) else $error("lock before adaptation done");

  a_adapt_setting: assert property (
    !byp_q[0][POS_BYPASS] |=> eqs_q[0] == {2'b00, $past(set_q[0])}
  ) else $error("adaptive setting wrong");

  a_limit_clear: assert property (
    seq_filt_read ##0 !eq_in[0].at_limit |=> !lim_flag_q[0]
  ) else $error("limit flag not cleared");

  a_settled_rearm: assert property (
    seq_filt_read ##0 eq_in[0].settled |=> stab_q[0]
  ) else $error("settled not re-armed");

  a_delay_read: assert property (
    seq_filt_read |=> rdata[5:0] == $past(eq_in[0].clk_delay)
  ) else $error("clock delay readback wrong");

  a_flag_read: assert property (
    seq_filt_read |=> rdata[7] == $past(lim_flag_q[0])
  ) else $error("limit flag readback wrong");

  a_ctl_write: assert property (
    seq_ctl_write |=> ctl_q[0] == {$past(req.wdata[7:2]), 2'b00}
  ) else $error("control write wrong");

  a_status_value: assert property (
    (req.rd && req.port == 2'd0 && req.addr == OFS_STATUS) |=> rdata == {2'b00, $past(eqs_q[0])}
  ) else $error("status value wrong");

endmodule

/* rtl/eq_ctl_pkg.sv */
package eq_ctl_pkg;

  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned NUM_PORTS = 4;

  localparam logic [7:0] OFS_CTL_TWO = 8'hd2;
  localparam logic [7:0] OFS_STATUS = 8'hd3;
  localparam logic [7:0] OFS_BYPASS = 8'hd4;
  localparam logic [7:0] OFS_LIMITS = 8'hd5;
  localparam logic [7:0] OFS_FILT0 = 8'hd6;

  localparam logic [7:0] RST_CTL_TWO = 8'h94;
  localparam logic [7:0] RST_BYPASS = 8'h60;
  localparam logic [7:0] RST_LIMITS = 8'hf2;

  // field positions
  localparam int unsigned POS_RELOCK = 5;
  localparam int unsigned POS_FIRST_LOCK = 4;
  localparam int unsigned POS_RESTART = 3;
  localparam int unsigned POS_FLOOR_EN = 2;
  localparam int unsigned POS_MAN_HIGH = 5;
  localparam int unsigned POS_LOCK_MODE = 4;
  localparam int unsigned POS_MAN_LOW = 1;
  localparam int unsigned POS_BYPASS = 0;
  localparam int unsigned POS_CEIL = 4;
  localparam int unsigned POS_FLOOR_VAL = 0;
  localparam int unsigned POS_AT_LIMIT = 7;
  localparam int unsigned POS_SETTLED = 6;

  // relock wait per code in ns: 164us .. 21.0ms
  localparam longint unsigned RELOCK_NS [8] = '{164000, 328000, 655000, 1310000,
                                                 2620000, 5240000, 10500000, 21000000};
  localparam int unsigned CLK_NS = 1000000000 / CLK_HZ;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [1:0] port;
  } reg_req_t;

  typedef struct packed {
    logic lock_raw;
    logic at_limit;
    logic settled;
    logic [5:0] clk_delay;
  } eq_in_t;

endpackage

/* verification/serializer_link_model.sv */
`timescale 1ns/1ps
module serializer_link_model
  import eq_ctl_pkg::*;
(
  input wire logic clk,
  input wire logic cable_ok [4],
  input wire logic [5:0] delay_in [4],
  output eq_ctl_pkg::eq_in_t eq_in [4]
);
  // filter counts as settled only while the delay holds still; the limit is one pulse
  always_ff @(posedge clk) begin
    for (int p = 0; p < 4; p++) begin
      eq_in[p].lock_raw <= cable_ok[p];
      eq_in[p].at_limit <= (delay_in[p] == 6'h3f) && (eq_in[p].clk_delay != 6'h3f);
      eq_in[p].settled <= (delay_in[p] == eq_in[p].clk_delay);
      eq_in[p].clk_delay <= delay_in[p];
    end
  end
endmodule

/* verification/rx_adaptive_equalizer_ctl_test.sv */
`timescale 1ns/1ps
module rx_adaptive_equalizer_ctl_test;
  import eq_ctl_pkg::*;
  logic clk, rst;
  reg_req_t req;
  eq_in_t eq_in [4];
  logic [7:0] rdata, junk;
  logic [5:0] eq_setting [4];
  logic lock_out [4];
  logic cable_ok [4];
  logic [5:0] dly [4];
  int fails, n_compared;
  rx_adaptive_equalizer_ctl u_rx_adaptive_equalizer_ctl (.clk(clk), .rst(rst), .req(req),
    .eq_in(eq_in), .rdata(rdata), .eq_setting(eq_setting), .lock_out(lock_out));
  serializer_link_model u_serializer_link_model (.clk(clk), .cable_ok(cable_ok),
    .delay_in(dly), .eq_in(eq_in));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic stop_test;
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [1:0] p, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 req = '{1'b1, 1'b0, a, d, p};
    @(posedge clk);
    #1 req.wr = 1'b0;
  endtask
  task automatic rd(input logic [1:0] p, input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 req = '{1'b0, 1'b1, a, 8'h00, p};
    @(posedge clk);
    #1 req.rd = 1'b0;
    d = rdata;
  endtask
  task automatic rc(input logic [1:0] p, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(p, a, d);
    chk($sformatf("reg %h port %0d", a, p), d, exp);
  endtask
  // bounded wait on the applied setting and lock of one port
  task automatic wait_out(input int p, input logic [6:0] exp, input int lim);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++) begin
      @(posedge clk);
      #1 hit = ({lock_out[p], eq_setting[p]} === exp);
    end
    chk("lock and setting", {1'b0, lock_out[p], eq_setting[p]}, {1'b0, exp});
    if (!hit) stop_test;
  endtask
  task automatic t_reset;
    rc(0, OFS_CTL_TWO, 8'h94);
    rc(0, OFS_STATUS, 8'h00);
    rc(0, OFS_BYPASS, 8'h60);
    rc(0, OFS_LIMITS, 8'hf2);
    rc(0, 8'hd1, 8'h00);
  endtask
  task automatic t_regs;
    wr(0, OFS_LIMITS, 8'h7a);
    rc(0, OFS_LIMITS, 8'h7a);
    wr(0, OFS_CTL_TWO, 8'h4b);
    repeat (3) @(posedge clk);
    rc(0, OFS_CTL_TWO, 8'h40);
  endtask
  task automatic t_bypass;
    wr(1, OFS_BYPASS, 8'hab);
    wait_out(1, 7'h2d, 10);
    rc(1, OFS_STATUS, 8'h2d);
    rc(0, OFS_BYPASS, 8'h60);
    cable_ok[1] = 1'b1;
    wait_out(1, 7'h6d, 10);
    cable_ok[1] = 1'b0;
    wait_out(1, 7'h2d, 10);
  endtask
  task automatic t_filter;
    rd(0, OFS_FILT0, junk);
    rc(0, OFS_FILT0, 8'h45);
    dly[0] = 6'h3f;
    repeat (4) @(posedge clk);
    rc(0, OFS_FILT0, 8'hbf);
    rc(0, OFS_FILT0, 8'h7f);
  endtask
  // shortest dwell is 4100 cycles; ceiling 1 makes the setting wrap to zero
  task automatic t_adapt;
    wr(0, OFS_LIMITS, 8'hf3);
    wr(0, OFS_CTL_TWO, 8'h0c);
    wait_out(0, 7'h03, 10);
    wr(0, OFS_LIMITS, 8'h13);
    wr(0, OFS_CTL_TWO, 8'h08);
    wait_out(0, 7'h00, 10);
    repeat (4000) @(posedge clk);
    #1 chk("setting in dwell", {2'b00, eq_setting[0]}, 8'h00);
    wait_out(0, 7'h01, 200);
    wait_out(0, 7'h00, 4200);
  endtask
  task automatic t_lock_mode;
    wr(0, OFS_BYPASS, 8'h10);
    wr(0, OFS_CTL_TWO, 8'h98);
    cable_ok[0] = 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("lock before adapt done", {7'h00, lock_out[0]}, 8'h00);
    wait_out(0, 7'h40, 10);
  endtask
  initial begin
    req = '0;
    rst = 1'b1;
    for (int p = 0; p < 4; p++) begin
      cable_ok[p] = 1'b0;
      dly[p] = 6'h05;
    end
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    t_reset();
    t_regs();
    t_bypass();
    t_filter();
    t_adapt();
    t_lock_mode();
    stop_test();
  end
endmodule
